//--- hw/digital_output_routing.sv
// Purpose: digital output stage with polarity, override and routing mode
// Assumes: encoder and position pulse inputs are asynchronous levels
// Notes: outputs open drain; pin low when enable high
//
// Behaviour
// - each setting bit acts only on the output at the same position
// - polarity clear: commanded one drives high; set: drives low
// - override bit set replaces commanded value, brake included
// - override value register holds level per overridden output
// - subentries one and five have no effect on outputs
// - routing enable one selects routed source per output
// - in routing mode polarity and override settings are ignored
// - five route configs map to brake, outputs one to four
// - route config sixteen bits: high byte source, low byte gate bit
// - selected gate bit switches routed source on or off
// - config bit seven set inverts gate sense
// - source 00 constant one, source 01 constant zero
// - sources 02 to 08 route encoder pulses divided 1 to 64
// - sources 09 to 0f route position pulses divided 1 to 64
// - no rate limit: every output takes its new level each clock cycle
// - command bit zero is brake, bits sixteen up are outputs
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module digital_output_routing
	import dout_route_pkg::*;
#(
	parameter int unsigned NUM_PHYS = 4
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pulse sources, asynchronous
	input wire logic encoder_pulse,
	input wire logic position_pulse,
	// open-drain output pins: brake, then outputs 1..4
	input wire logic [NUM_OUT-1:0] out_pin_in,
	output logic [NUM_OUT-1:0] out_pin_out,
	output logic [NUM_OUT-1:0] out_pin_oe
);
	if (NUM_PHYS != NUM_OUT - 1) begin : g_phys_check
		$error("NUM_PHYS must be 4");
	end

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACCESS = 2'b01
	} bus_state_t;

	logic [31:0] command_reg;
	logic [31:0] sub1_reg;
	logic [31:0] polarity_reg;
	logic [31:0] ovr_en_reg;
	logic [31:0] ovr_val_reg;
	logic [31:0] sub5_reg;
	logic route_en_reg;
	route_cfg_t route_reg [NUM_OUT];
	bus_state_t bus_reg;
	apb_req_t req;
	logic wr_go;
	logic rd_go;
	logic [1:0] enc_sync_reg;
	logic [1:0] pos_sync_reg;
	logic [1:0] pin_sync0_reg [NUM_OUT];
	logic [DIV_STAGES:0] enc_div_reg;
	logic [DIV_STAGES:0] pos_div_reg;
	logic [NUM_OUT-1:0] level_next;
	logic [NUM_OUT-1:0] pin_state;
	logic [NUM_OUT-1:0] ovr_level;
	logic [NUM_OUT-1:0] cmd_level;

	// command bit for output index: brake at bit 0, outputs from bit 16
	function automatic int unsigned cmd_pos(input int unsigned idx);
		cmd_pos = (idx == 0) ? BRAKE_BIT : FIRST_OUT_BIT + idx - 1;
	endfunction : cmd_pos

	// divided pulse train selected by divider stage 0..6
	function automatic logic div_pick(input logic [DIV_STAGES:0] d, input logic [7:0] s);
		div_pick = d[s[2:0]];
	endfunction : div_pick

	assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
	assign wr_go = psel && penable && req.write && (bus_reg == BUS_ACCESS);
	assign rd_go = psel && !req.write && (bus_reg == BUS_IDLE);

	// zero wait state slave: ready in the access cycle
	always_ff @(posedge clock) begin
		if (srst) begin
			bus_reg <= BUS_IDLE;
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
			bus_reg <= (psel && !penable) ? BUS_ACCESS : BUS_IDLE;
		end
	end

	// read data and error answer captured in setup cycle
	always_ff @(posedge clock) begin
		if (srst) begin
			prdata <= RST_WORD;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata <= RST_WORD;
			pslverr <= 1'b0;
			if (rd_go) begin
				case (req.addr)
				OFS_COMMAND: prdata <= command_reg;
				OFS_SUB1: prdata <= sub1_reg;
				OFS_POLARITY: prdata <= polarity_reg;
				OFS_OVR_EN: prdata <= ovr_en_reg;
				OFS_OVR_VAL: prdata <= ovr_val_reg;
				OFS_SUB5: prdata <= sub5_reg;
				OFS_ROUTE_EN: prdata <= {31'h0, route_en_reg};
				OFS_PIN_STATE: prdata <= {27'h0, pin_state};
				default: begin
					if (req.addr >= OFS_ROUTE_CFG0 && req.addr < OFS_ROUTE_CFG0 + 12'h014
						&& req.addr[1:0] == 2'b00)
						prdata <= {16'h0, route_reg[3'((req.addr - OFS_ROUTE_CFG0) >> 2)]};
					else
						pslverr <= 1'b1;
				end
				endcase
			end else begin
				pslverr <= !(req.addr inside {OFS_COMMAND, OFS_SUB1, OFS_POLARITY,
					OFS_OVR_EN, OFS_OVR_VAL, OFS_SUB5, OFS_ROUTE_EN}
					|| (req.addr >= OFS_ROUTE_CFG0 && req.addr < OFS_ROUTE_CFG0 + 12'h014
					&& req.addr[1:0] == 2'b00));
			end
		end
	end

	// register writes
	always_ff @(posedge clock) begin
		if (srst) begin
			command_reg <= RST_WORD;
			sub1_reg <= RST_WORD;
			polarity_reg <= RST_WORD;
			ovr_en_reg <= RST_WORD;
			ovr_val_reg <= RST_WORD;
			sub5_reg <= RST_WORD;
			route_en_reg <= 1'b0;
			for (int i = 0; i < NUM_OUT; i++)
				route_reg[i] <= RST_ROUTE;
		end else if (wr_go) begin
			case (req.addr)
			OFS_COMMAND: command_reg <= req.wdata;
			OFS_SUB1: sub1_reg <= req.wdata;
			OFS_POLARITY: polarity_reg <= req.wdata;
			OFS_OVR_EN: ovr_en_reg <= req.wdata;
			OFS_OVR_VAL: ovr_val_reg <= req.wdata;
			OFS_SUB5: sub5_reg <= req.wdata;
			OFS_ROUTE_EN: route_en_reg <= req.wdata[0];
			default: begin
				for (int i = 0; i < NUM_OUT; i++)
					if (req.addr == OFS_ROUTE_CFG0 + 12'(4 * i))
						route_reg[i] <= req.wdata[15:0];
			end
			endcase
		end
	end

	// two flop synchronisers for pulse sources and pin readback
	always_ff @(posedge clock) begin
		if (srst) begin
			enc_sync_reg <= 2'b00;
			pos_sync_reg <= 2'b00;
			for (int i = 0; i < NUM_OUT; i++)
				pin_sync0_reg[i] <= 2'b00;
		end else begin
			enc_sync_reg <= {enc_sync_reg[0], encoder_pulse};
			pos_sync_reg <= {pos_sync_reg[0], position_pulse};
			for (int i = 0; i < NUM_OUT; i++)
				pin_sync0_reg[i] <= {pin_sync0_reg[i][0], out_pin_in[i]};
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_OUT; i++)
			pin_state[i] = pin_sync0_reg[i][1];
	end

	// bit 0 follows the source, bits above count its rises: bit k divides by 2^k
	function automatic logic [DIV_STAGES:0] div_step(input logic [DIV_STAGES:0] d,
		input logic now);
		div_step = d;
		div_step[0] = now;
		if (now && !d[0])
			div_step[DIV_STAGES:1] = d[DIV_STAGES:1] + 1'b1;
	endfunction : div_step

	// divider chains; bit 0 doubles as the edge detector's last value
	always_ff @(posedge clock) begin
		if (srst) begin
			enc_div_reg <= '0;
			pos_div_reg <= '0;
		end else begin
			enc_div_reg <= div_step(enc_div_reg, enc_sync_reg[1]);
			pos_div_reg <= div_step(pos_div_reg, pos_sync_reg[1]);
		end
	end

	// normal path per output
	always_comb begin
		for (int i = 0; i < NUM_OUT; i++) begin
			cmd_level[i] = command_reg[cmd_pos(i)] ^ polarity_reg[cmd_pos(i)];
			ovr_level[i] = ovr_en_reg[cmd_pos(i)] ? ovr_val_reg[cmd_pos(i)]
				: cmd_level[i];
		end
	end

	// routed or normal level
	always_comb begin
		level_next = '0;
		for (int i = 0; i < NUM_OUT; i++) begin
			logic gate_on;
			logic [7:0] src;
			gate_on = 1'b0;
			src = route_reg[i].source;
			if (!route_en_reg) begin
				level_next[i] = ovr_level[i];
			end else begin
				gate_on = command_reg[route_reg[i].gate[4:0]]
					^ route_reg[i].gate[CFG_INV_BIT];
				if (src == SRC_CONST1)
					level_next[i] = gate_on;
				else if (src == SRC_CONST0)
					level_next[i] = 1'b0;
				else if (src >= SRC_ENC_LO && src <= SRC_ENC_HI)
					level_next[i] = gate_on && div_pick(enc_div_reg, src - SRC_ENC_LO);
				else if (src >= SRC_POS_LO && src <= SRC_POS_HI)
					level_next[i] = gate_on && div_pick(pos_div_reg, src - SRC_POS_LO);
				else
					level_next[i] = 1'b0;
			end
		end
	end

	// registered pins; all outputs share one update rate, fast enough for 10 khz
	always_ff @(posedge clock) begin
		if (srst) begin
			out_pin_out <= '0;
			out_pin_oe <= '1;
		end else begin
			out_pin_out <= '0;
			out_pin_oe <= ~level_next;
		end
	end

	property p_route_off_follow;
		@(posedge clock) disable iff (srst)
		!route_en_reg && !ovr_en_reg[BRAKE_BIT] |=> out_pin_oe[0] == $past(~(command_reg[0]
			^ polarity_reg[0]));
	endproperty
	a_route_off_follow: assert property (p_route_off_follow) else $error("brake level");

	property p_override;
		@(posedge clock) disable iff (srst)
		!route_en_reg && ovr_en_reg[16] |=> out_pin_oe[1] == !$past(ovr_val_reg[16]);
	endproperty
	a_override: assert property (p_override) else $error("override ignored");

	property p_const0;
		@(posedge clock) disable iff (srst)
		route_en_reg && route_reg[2].source == SRC_CONST0 |=> out_pin_oe[2];
	endproperty
	a_const0: assert property (p_const0) else $error("const0 not low");

	property p_undefined;
		@(posedge clock) disable iff (srst)
		route_en_reg && route_reg[3].source > SRC_POS_HI |=> out_pin_oe[3];
	endproperty
	a_undefined: assert property (p_undefined) else $error("undefined source active");

	sequence s_setup;
		psel && !penable;
	endsequence
	property p_ready;
		@(posedge clock) disable iff (srst)
		s_setup |=> pready ##1 !pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready timing");

	property p_gate;
		@(posedge clock) disable iff (srst)
		route_en_reg && route_reg[4].source == SRC_CONST1
			&& (command_reg[route_reg[4].gate[4:0]] == route_reg[4].gate[CFG_INV_BIT])
			|=> out_pin_oe[4];
	endproperty
	a_gate: assert property (p_gate) else $error("gate off but driven");

	property p_no_drive_high;
		@(posedge clock) disable iff (srst)
		1'b1 |-> out_pin_out == '0;
	endproperty
	a_no_drive_high: assert property (p_no_drive_high) else $error("pin driven high");

	property p_route_write;
		@(posedge clock) disable iff (srst)
		wr_go && req.addr == OFS_ROUTE_EN |=> route_en_reg == $past(pwdata[0]);
	endproperty
	a_route_write: assert property (p_route_write) else $error("route enable lost");

	// output 2 follows command bit 17 alone; neighbours must not leak in
	property p_out2_own_bit;
		@(posedge clock) disable iff (srst)
		!route_en_reg && !ovr_en_reg[17]
			|=> out_pin_oe[2] == $past(~(command_reg[17] ^ polarity_reg[17]));
	endproperty
	a_out2_own_bit: assert property (p_out2_own_bit) else $error("out2 level");

	property p_out3_polarity;
		@(posedge clock) disable iff (srst)
		!route_en_reg && !ovr_en_reg[18]
			|=> out_pin_oe[3] == $past(~(command_reg[18] ^ polarity_reg[18]));
	endproperty
	a_out3_polarity: assert property (p_out3_polarity) else $error("out3 level");

	property p_brake_override;
		@(posedge clock) disable iff (srst)
		!route_en_reg && ovr_en_reg[BRAKE_BIT]
			|=> out_pin_oe[0] == !$past(ovr_val_reg[BRAKE_BIT]);
	endproperty
	a_brake_override: assert property (p_brake_override) else $error("brake override");

	property p_out4_override;
		@(posedge clock) disable iff (srst)
		!route_en_reg && ovr_en_reg[19]
			|=> out_pin_oe[4] == !$past(ovr_val_reg[19]);
	endproperty
	a_out4_override: assert property (p_out4_override) else $error("out4 override");

	// brake config and the command bit it gates on decide the brake pin in routing mode
	property p_route_brake_on;
		@(posedge clock) disable iff (srst)
		route_en_reg && route_reg[0].source == SRC_CONST1
			&& (command_reg[route_reg[0].gate[4:0]] != route_reg[0].gate[CFG_INV_BIT])
			|=> !out_pin_oe[0];
	endproperty
	a_route_brake_on: assert property (p_route_brake_on) else $error("brake not released");

	// a held encoder level crosses two sync stages, the divider and the pin flop
	sequence s_enc_out1;
		route_en_reg && route_reg[1].source == SRC_ENC_LO && encoder_pulse
			&& (command_reg[route_reg[1].gate[4:0]] != route_reg[1].gate[CFG_INV_BIT]);
	endsequence
	property p_enc_follow;
		@(posedge clock) disable iff (srst)
		s_enc_out1 [*4] |=> !out_pin_oe[1];
	endproperty
	a_enc_follow: assert property (p_enc_follow) else $error("encoder not routed");

	// compatibility words are stored but never reach a pin
	property p_sub_no_effect;
		@(posedge clock) disable iff (srst)
		!route_en_reg && wr_go && (req.addr == OFS_SUB1 || req.addr == OFS_SUB5)
			|=> ##1 $stable(out_pin_oe);
	endproperty
	a_sub_no_effect: assert property (p_sub_no_effect) else $error("sub word on pin");

	property p_cfg_write;
		@(posedge clock) disable iff (srst)
		wr_go && req.addr == OFS_ROUTE_CFG0 |=> route_reg[0] == $past(pwdata[15:0]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("route config lost");
endmodule : digital_output_routing

//--- hw/dout_route_pkg.sv
// Purpose: constants and carriers for the digital output routing block
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes: register offsets are local byte addresses
package dout_route_pkg;
	localparam int unsigned NUM_OUT = 5;
	localparam logic [11:0] OFS_COMMAND = 12'h000;
	localparam logic [11:0] OFS_SUB1 = 12'h004;
	localparam logic [11:0] OFS_POLARITY = 12'h008;
	localparam logic [11:0] OFS_OVR_EN = 12'h00c;
	localparam logic [11:0] OFS_OVR_VAL = 12'h010;
	localparam logic [11:0] OFS_SUB5 = 12'h014;
	localparam logic [11:0] OFS_ROUTE_EN = 12'h020;
	localparam logic [11:0] OFS_ROUTE_CFG0 = 12'h040;
	localparam logic [11:0] OFS_PIN_STATE = 12'h060;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_ROUTE = 16'h0100;
	localparam int unsigned BRAKE_BIT = 0;
	localparam int unsigned FIRST_OUT_BIT = 16;
	localparam int unsigned CFG_INV_BIT = 7;
	localparam logic [7:0] SRC_CONST1 = 8'h00;
	localparam logic [7:0] SRC_CONST0 = 8'h01;
	localparam logic [7:0] SRC_ENC_LO = 8'h02;
	localparam logic [7:0] SRC_ENC_HI = 8'h08;
	localparam logic [7:0] SRC_POS_LO = 8'h09;
	localparam logic [7:0] SRC_POS_HI = 8'h0f;
	localparam int unsigned DIV_STAGES = 6;
	localparam int unsigned FAST_OUTS = 3;
	localparam int unsigned CLOCK_HZ = 20_000_000;
	localparam int unsigned FAST_HZ = 10_000;
	localparam int unsigned SLOW_HZ = 500;
	// least half period of routed signal, in cycles
	localparam int unsigned FAST_HALF_CYC = CLOCK_HZ / (2 * FAST_HZ);
	localparam int unsigned SLOW_HALF_CYC = CLOCK_HZ / (2 * SLOW_HZ);
	typedef struct packed {
		logic [7:0] source;
		logic [7:0] gate;
	} route_cfg_t;
	typedef struct packed {
		logic [11:0] addr;
		logic write;
		logic [31:0] wdata;
	} apb_req_t;
endpackage : dout_route_pkg

//--- tb/open_drain_load.sv
// Purpose: pull-up loads on the open-drain output pins
// Assumes: oe high sinks the pin, otherwise the external pull-up wins
// Notes: the wire level is fed back to the readback inputs
`timescale 1ns/1ps
module open_drain_load
	import dout_route_pkg::*;
(
	// drive from the device
	input wire logic [NUM_OUT-1:0] pin_oe,
	input wire logic [NUM_OUT-1:0] pin_out,
	// resulting wire level
	output logic [NUM_OUT-1:0] pin_level
);
	// a released pin never keeps its last value: the supply pulls it up
	always_comb begin
		for (int k = 0; k < NUM_OUT; k++) begin
			pin_level[k] = pin_oe[k] ? pin_out[k] : 1'b1;
		end
	end
endmodule : open_drain_load

//--- tb/test_digital_output_routing.sv
// Purpose: self-checking bench for the digital output routing block
// Assumes: zero-wait apb slave, pull-up loads on every output pin
// Notes: pulse checks hold each level just past the 10 khz half period
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_digital_output_routing;
	import dout_route_pkg::*;
	logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err, enc = 0, pos = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, r, seed = 32'h9511, cmd = 0, pol = 0, oen = 0, ov = 0;
	logic pready, pslverr;
	logic [4:0] pin_out, pin_oe, pin_lvl, prev;
	logic [15:0] cfg [5];
	logic [7:0] src;
	logic [7:0] srcs [4] = '{SRC_CONST1, SRC_CONST0, SRC_CONST1, 8'h10};
	logic [7:0] psrc [3] = '{SRC_ENC_LO, SRC_ENC_LO + 8'h02, SRC_POS_LO + 8'h01};
	int prise [3] = '{8, 2, 4};
	int n_mismatch = 0, n_checks = 0, rises = 0, r0;

	always #25 clock = ~clock;

	digital_output_routing i_digital_output_routing (.clock(clock), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .encoder_pulse(enc),
		.position_pulse(pos), .out_pin_in(pin_lvl), .out_pin_out(pin_out),
		.out_pin_oe(pin_oe));
	open_drain_load i_open_drain_load (.pin_oe(pin_oe), .pin_out(pin_out),
		.pin_level(pin_lvl));

	always @(posedge clock) begin
		prev <= pin_lvl;
		if (pin_lvl[1] && !prev[1]) rises <= rises + 1;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	function automatic logic [4:0] exp_norm();
		logic [4:0] l;
		int b;
		for (int k = 0; k < 5; k++) begin
			b = (k == 0) ? BRAKE_BIT : FIRST_OUT_BIT + k - 1;
			l[k] = oen[b] ? ov[b] : cmd[b] ^ pol[b];
		end
		return l;
	endfunction : exp_norm

	// only a gated constant-one source ends high; 01 and undefined codes stay low
	function automatic logic [4:0] exp_route();
		logic [4:0] l;
		for (int k = 0; k < 5; k++) begin
			l[k] = (cfg[k][15:8] == SRC_CONST1) && (cmd[cfg[k][4:0]] ^ cfg[k][CFG_INV_BIT]);
		end
		return l;
	endfunction : exp_route

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// no assumed latency: only the watchdog ends a stuck access
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task put_norm();
		apb(1'b1, OFS_COMMAND, cmd);
		apb(1'b1, OFS_POLARITY, pol);
		apb(1'b1, OFS_OVR_EN, oen);
		apb(1'b1, OFS_OVR_VAL, ov);
	endtask : put_norm

	task chk_pins(input logic [4:0] e);
		repeat (3) @(posedge clock);
		`CHK("pin level", e, pin_lvl)
	endtask : chk_pins

	task tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (90000) @(posedge clock);
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		for (int k = 0; k < 5; k++) cfg[k] = RST_ROUTE;
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		apb(1'b0, OFS_POLARITY, 32'h0000_0000);
		`CHK("polarity reset", RST_WORD, rd)
		apb(1'b0, OFS_ROUTE_CFG0, 32'h0000_0000);
		`CHK("route reset", {16'h0000, RST_ROUTE}, rd)
		chk_pins(5'h00);
		`CHK("pin drive", 5'h00, pin_out)
		apb(1'b1, 12'h100, xs());
		`CHK("unmapped error", 1'b1, err)
		repeat (24) begin
			cmd = xs();
			pol = xs();
			oen = xs();
			ov = xs();
			put_norm();
			apb(1'b1, OFS_SUB1, xs());
			apb(1'b1, OFS_SUB5, xs());
			chk_pins(exp_norm());
			apb(1'b0, OFS_PIN_STATE, 32'h0000_0000);
			`CHK("pin readback", {27'h0, exp_norm()}, rd)
		end
		apb(1'b0, OFS_OVR_VAL, 32'h0000_0000);
		`CHK("override readback", ov, rd)
		cmd = 32'h0000_0000;
		pol = 32'hffff_ffff;
		oen = 32'h0000_0000;
		put_norm();
		chk_pins(5'h1f);
		apb(1'b1, OFS_ROUTE_EN, 32'h0000_0001);
		for (int k = 0; k < 5; k++) begin
			for (int s = 0; s < 4; s++) begin
				r = xs();
				src = srcs[s] | ((s == 3) ? r[23:16] : 8'h00);
				cfg[k] = {src, r[7], 2'b00, r[4:0]};
				cmd = xs();
				pol = xs();
				oen = xs();
				ov = xs();
				put_norm();
				apb(1'b1, OFS_ROUTE_CFG0 + 12'(4 * k), {16'h0000, cfg[k]});
				chk_pins(exp_route());
			end
		end
		cmd = 32'h0000_0001;
		apb(1'b1, OFS_COMMAND, cmd);
		for (int p = 0; p < 3; p++) begin
			apb(1'b1, OFS_ROUTE_CFG0 + 12'h004, {16'h0000, psrc[p], 8'h00});
			// levels held just past the fastest routed half period
			repeat (FAST_HALF_CYC + 100) @(posedge clock);
			r0 = rises;
			repeat (8) begin
				if (p == 2) pos <= 1'b1;
				else enc <= 1'b1;
				repeat (FAST_HALF_CYC + 100) @(posedge clock);
				pos <= 1'b0;
				enc <= 1'b0;
				repeat (FAST_HALF_CYC + 100) @(posedge clock);
			end
			`CHK("routed rises", prise[p], rises - r0)
		end
		apb(1'b1, OFS_ROUTE_EN, 32'h0000_0000);
		cmd = xs();
		put_norm();
		chk_pins(exp_norm());
		// mid-run reset: pins sink while held and settings return to defaults
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		`CHK("pins in reset", 5'h00, pin_lvl)
		srst <= 1'b0;
		apb(1'b0, OFS_ROUTE_EN, 32'h0000_0000);
		`CHK("route enable reset", RST_WORD, rd)
		chk_pins(5'h00);
		tally_and_finish();
	end
endmodule : test_digital_output_routing
